// ### pkg/pib_defines.svh
// Constants of the parallel instrument bus interface
`ifndef PIB_DEFINES_SVH
`define PIB_DEFINES_SVH
`define PIB_LISTEN_BASE   8'h0020
`define PIB_TALK_BASE     8'h0040
`define PIB_GROUP_MASK    8'h0060
`define PIB_SECONDARY_GRP 8'h0060
`define PIB_ADDR_MASK     8'h001F
`define PIB_UNLISTEN      8'h003F
`define PIB_UNTALK        8'h005F
`define PIB_CMD_MASK      8'h007F
`define PIB_ADDR_MAX      5'h001E
`define PIB_SETTLE_NS     100
`define PIB_CLK_NS        50
`define PIB_SETTLE_CYC    ((`PIB_SETTLE_NS + `PIB_CLK_NS - 1) / `PIB_CLK_NS)
`endif

// ### pkg/pib_pkg.sv
// Types shared by the parallel instrument bus interface
`default_nettype none
package pib_pkg;
  // Bus line bundle, true level (1 = asserted, low on the wire)
  typedef struct packed {
    logic [7:0] dio;
    logic       dav;
    logic       nrfd;
    logic       ndac;
    logic       atn;
    logic       ifc;
    logic       ren;
    logic       eoi;
  } pib_lines_s;

  // One byte with its end flag
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } pib_word_s;

  // Source handshake states, Gray along the path
  typedef enum logic [1:0] {
    PIB_SRC_IDLE = 2'b00,
    PIB_SRC_WAIT = 2'b01,
    PIB_SRC_VALID = 2'b11,
    PIB_SRC_DONE = 2'b10
  } pib_src_e;

  // Acceptor handshake states, Gray along the path except the return from hold to ready
  typedef enum logic [1:0] {
    PIB_ACC_READY = 2'b00,
    PIB_ACC_TAKE = 2'b01,
    PIB_ACC_HOLD = 2'b11
  } pib_acc_e;
endpackage
`default_nettype wire

// ### hw/pib_sync.sv
// Three-stage synchroniser with agreement filter for one bus line
`timescale 1ns/1ps
`default_nettype none
module pib_sync (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic pin_n,
  output var  logic level
);
  logic [2:0] sh_r;

  // A change counts once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sh_r  <= 3'b111;
      level <= 1'b0;
    end else begin
      sh_r <= {sh_r[1:0], pin_n};
      if (sh_r[1] == sh_r[2]) begin
        level <= ~sh_r[2];
      end
    end
  end
endmodule // pib_sync

// ### hw/pib_buf.sv
// Two-entry skid buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pib_buf
  import pib_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      nrst,
  input  wire logic      in_valid,
  output logic           in_ready,
  input  wire pib_word_s in_word,
  output logic           out_valid,
  input  wire logic      out_ready,
  output pib_word_s      out_word
);
  typedef struct packed {
    pib_word_s [1:0] mem;
    logic [1:0]      cnt;
  } pib_buf_s;

  pib_buf_s st_r;
  pib_buf_s st_nxt;

  assign in_ready  = (st_r.cnt != 2'd2);
  assign out_valid = (st_r.cnt != 2'd0);
  assign out_word  = st_r.mem[0];

  // Pop from slot 0, push behind the last held word
  always_comb begin
    st_nxt = st_r;
    if (out_valid && out_ready) begin
      st_nxt.mem[0] = st_r.mem[1];
      st_nxt.cnt    = st_r.cnt - 2'd1;
    end
    if (in_valid && in_ready) begin
      st_nxt.mem[st_nxt.cnt[0]] = in_word;
      st_nxt.cnt                = st_nxt.cnt + 2'd1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule // pib_buf

// ### hw/pib_core.sv
// Talker/listener interface for the parallel instrument bus
`timescale 1ns/1ps
`default_nettype none
`include "pib_defines.svh"
module pib_core
  import pib_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [4:0] prim_addr,
  input  wire logic [7:0] dio_n_i,
  output logic [7:0]      dio_n_o,
  output logic            dio_oe,
  input  wire logic       dav_n_i,
  output logic            dav_n_o,
  output logic            dav_oe,
  input  wire logic       nrfd_n_i,
  output logic            nrfd_n_o,
  output logic            nrfd_oe,
  input  wire logic       ndac_n_i,
  output logic            ndac_n_o,
  output logic            ndac_oe,
  input  wire logic       eoi_n_i,
  output logic            eoi_n_o,
  output logic            eoi_oe,
  input  wire logic       atn_n,
  input  wire logic       ifc_n,
  input  wire logic       ren_n,
  output logic            srq_n_o,
  output logic            srq_oe,
  input  wire logic       svc_req,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire pib_word_s  tx_word,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output pib_word_s       rx_word,
  output logic            listen_act,
  output logic            talk_act,
  output logic            remote,
  output logic            addr_err
);
  typedef struct packed {
    pib_src_e   src;
    pib_acc_e   acc;
    logic [7:0] tx_data;
    logic       tx_last;
    logic       lad;
    logic       tad;
    logic       rem;
    logic       bad_addr;
    logic [1:0] settle;
    pib_word_s  rx_hold;
    logic       rx_push;
    logic       atn_prev;
  } pib_core_s;

  localparam logic [1:0] SETTLE_CYC = 2'(`PIB_SETTLE_CYC);

  pib_core_s  st_r;
  pib_core_s  st_nxt;
  pib_lines_s bus;
  logic [7:0] my_listen;
  logic [7:0] my_talk;
  logic [7:0] cmd;
  logic       buf_in_ready;
  logic       acc_on;
  logic       settling;
  logic [4:0] addr_ok;

  // Synchronise every incoming line, dio plus seven controls
  pib_sync u_sync_dio [7:0] (.core_clk(core_clk), .nrst(nrst), .pin_n(dio_n_i), .level(bus.dio));
  pib_sync u_sync_dav  (.core_clk(core_clk), .nrst(nrst), .pin_n(dav_n_i),  .level(bus.dav));
  pib_sync u_sync_nrfd (.core_clk(core_clk), .nrst(nrst), .pin_n(nrfd_n_i), .level(bus.nrfd));
  pib_sync u_sync_ndac (.core_clk(core_clk), .nrst(nrst), .pin_n(ndac_n_i), .level(bus.ndac));
  pib_sync u_sync_atn  (.core_clk(core_clk), .nrst(nrst), .pin_n(atn_n),    .level(bus.atn));
  pib_sync u_sync_ifc  (.core_clk(core_clk), .nrst(nrst), .pin_n(ifc_n),    .level(bus.ifc));
  pib_sync u_sync_ren  (.core_clk(core_clk), .nrst(nrst), .pin_n(ren_n),    .level(bus.ren));
  pib_sync u_sync_eoi  (.core_clk(core_clk), .nrst(nrst), .pin_n(eoi_n_i),  .level(bus.eoi));

  // Address values 31 fold to 30 would collide with unlisten, so clamp invalid ones
  assign addr_ok   = (prim_addr > `PIB_ADDR_MAX) ? `PIB_ADDR_MAX : prim_addr;
  assign my_listen = {3'b000, addr_ok} | `PIB_LISTEN_BASE;
  assign my_talk   = {3'b000, addr_ok} | `PIB_TALK_BASE;
  assign cmd       = bus.dio & `PIB_CMD_MASK; // Top data bit is ignored in commands

  // Receive path buffer so a stalled user loses no byte
  pib_buf u_rx_buf (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .in_valid  (st_r.rx_push),
    .in_ready  (buf_in_ready),
    .in_word   (st_r.rx_hold),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_word  (rx_word)
  );

  // Acceptor joins only under attention or while listening; otherwise it keeps off both lines,
  // else an idle or talking device would hold accepted low and stall every transfer
  assign acc_on   = bus.atn || st_r.lad;
  // Not ready from the very attention edge until the settle count runs out
  assign settling = (bus.atn && !st_r.atn_prev) || (st_r.settle != 2'd0);

  // Next-state logic for the whole interface
  always_comb begin
    st_nxt         = st_r;
    st_nxt.rx_push = 1'b0;
    st_nxt.rem     = bus.ren;
    st_nxt.atn_prev = bus.atn;

    // Settle counter restarts on every attention assertion
    if (bus.atn && !st_r.atn_prev) begin
      st_nxt.settle = SETTLE_CYC;
    end else if (st_r.settle != 2'd0) begin
      st_nxt.settle = st_r.settle - 2'd1;
    end

    // Acceptor side: takes every byte under attention, data only when listening
    case (st_r.acc)
      PIB_ACC_READY: begin
        if (bus.dav && !settling && acc_on && buf_in_ready) begin
          st_nxt.acc = PIB_ACC_TAKE;
          if (bus.atn) begin
            if ((cmd & `PIB_GROUP_MASK) == `PIB_SECONDARY_GRP) begin
              st_nxt.bad_addr = 1'b1;
            end else if (cmd == `PIB_UNLISTEN) begin
              st_nxt.lad = 1'b0;
            end else if (cmd == `PIB_UNTALK) begin
              st_nxt.tad = 1'b0;
            end else if (cmd == my_listen) begin
              st_nxt.lad = 1'b1;
              st_nxt.bad_addr = 1'b0;
            end else if (cmd == my_talk) begin
              st_nxt.tad = 1'b1;
              st_nxt.bad_addr = 1'b0;
            end else if ((cmd & `PIB_GROUP_MASK) == `PIB_TALK_BASE) begin
              st_nxt.tad = 1'b0; // Another talker addressed
            end
          end else begin
            st_nxt.rx_hold.data = bus.dio;
            st_nxt.rx_hold.last = bus.eoi;
            st_nxt.rx_push      = 1'b1;
          end
        end
      end
      PIB_ACC_TAKE: begin
        st_nxt.acc = PIB_ACC_HOLD; // Accepted released this state
      end
      PIB_ACC_HOLD: begin
        if (!bus.dav) begin
          st_nxt.acc = PIB_ACC_READY;
        end
      end
      default: st_nxt.acc = PIB_ACC_READY;
    endcase

    // Source side: start a byte only while addressed and attention is off
    case (st_r.src)
      PIB_SRC_IDLE: begin
        if (st_r.tad && !bus.atn && tx_valid) begin
          st_nxt.tx_data = tx_word.data;
          st_nxt.tx_last = tx_word.last;
          st_nxt.src     = PIB_SRC_WAIT;
        end
      end
      PIB_SRC_WAIT: begin
        if (!bus.nrfd && bus.ndac) begin
          st_nxt.src = PIB_SRC_VALID;
        end
      end
      PIB_SRC_VALID: begin
        if (!bus.ndac) begin
          st_nxt.src = PIB_SRC_DONE;
        end
      end
      PIB_SRC_DONE: begin
        st_nxt.src = PIB_SRC_IDLE;
      end
      default: st_nxt.src = PIB_SRC_IDLE;
    endcase

    // Attention aborts a pending talk byte before data valid
    if (bus.atn && st_r.src == PIB_SRC_WAIT) begin
      st_nxt.src = PIB_SRC_IDLE;
    end

    // Interface clear wins over every other update of the address, error and handshake state
    if (bus.ifc) begin
      st_nxt.lad = 1'b0;
      st_nxt.tad = 1'b0;
      st_nxt.src = PIB_SRC_IDLE;
      st_nxt.acc = PIB_ACC_READY;
      st_nxt.bad_addr = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Handshake taken when the byte is loaded in idle
  assign tx_ready = (st_r.src == PIB_SRC_IDLE) && st_r.tad && !bus.atn && !bus.ifc;

  // Pin drive: active low wire, oe high when we drive
  assign dio_oe   = (st_r.src != PIB_SRC_IDLE);
  assign dio_n_o  = ~st_r.tx_data;
  assign eoi_oe   = dio_oe && st_r.tx_last;
  assign eoi_n_o  = 1'b0;
  assign dav_oe   = (st_r.src == PIB_SRC_VALID);
  assign dav_n_o  = 1'b0;
  // Acceptor: hold not-ready low unless idle and able, hold not-accepted low until taken;
  // a device standing aside releases both
  assign nrfd_oe  = (st_r.acc != PIB_ACC_READY) || (acc_on && (!buf_in_ready || settling));
  assign nrfd_n_o = 1'b0;
  assign ndac_oe  = (st_r.acc == PIB_ACC_READY) && acc_on;
  assign ndac_n_o = 1'b0;
  assign srq_oe   = svc_req;
  assign srq_n_o  = 1'b0;

  assign listen_act = st_r.lad;
  assign talk_act   = st_r.tad;
  assign remote     = st_r.rem;
  assign addr_err   = st_r.bad_addr;
endmodule // pib_core
`default_nettype wire

// ### tb/pib_core_properties.sv
// Port-level checks on the bus interface core
`timescale 1ns/1ps
`default_nettype none
module pib_core_properties (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic dav_n_i,
  input wire logic nrfd_n_i,
  input wire logic ndac_n_i,
  input wire logic ifc_n,
  input wire logic ren_n,
  input wire logic svc_req,
  input wire logic dio_oe,
  input wire logic dav_oe,
  input wire logic nrfd_oe,
  input wire logic ndac_oe,
  input wire logic srq_oe,
  input wire logic listen_act,
  input wire logic talk_act,
  input wire logic remote
);
  // One domain, so one clock and one reset for all checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // Source side
  dav_data_a: assert property (dav_oe |-> dio_oe)
    else $error("dav without data");
  dav_ready_a: assert property ($rose(dav_oe) |-> nrfd_n_i && !ndac_n_i)
    else $error("dav before acceptors ready");
  dav_drop_a: assert property ($fell(dav_oe) |-> ndac_n_i)
    else $error("dav dropped before accept");
  talker_only_a: assert property (dav_oe |-> talk_act)
    else $error("dav driven while not talker");
  // Acceptor side: ndac released with nrfd held while dav is low, or both let go with dav high
  take_order_a: assert property ($fell(ndac_oe) |-> nrfd_oe == !dav_n_i)
    else $error("accept out of order");
  // Management lines; eight cycles covers the synchroniser delay
  ifc_clear_a: assert property (!ifc_n [*8] |-> !listen_act && !talk_act)
    else $error("clear did not idle");
  ren_remote_a: assert property (!ren_n [*8] |-> remote)
    else $error("remote not set");
  srq_follow_a: assert property (srq_oe == svc_req)
    else $error("srq differs from request");

  cover property ($rose(listen_act));
  cover property ($rose(talk_act));
  cover property ($fell(dav_oe));
endmodule // pib_core_properties
`default_nettype wire

// ### tb/pib_ctrl_model.sv
// Bus controller model: source and acceptor on wired-low lines
`timescale 1ns/1ps
`default_nettype none
module pib_ctrl_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] dio_n_o,
  input  wire logic       dio_oe,
  input  wire logic       dav_oe,
  input  wire logic       nrfd_oe,
  input  wire logic       ndac_oe,
  input  wire logic       eoi_oe,
  output logic [7:0]      dio_n_i,
  output logic            dav_n_i,
  output logic            nrfd_n_i,
  output logic            ndac_n_i,
  output logic            eoi_n_i,
  output var logic        atn_n
);
  logic [7:0] m_dio = 8'h00;
  logic       m_dav = 1'b0, m_nrfd = 1'b0, m_ndac = 1'b0, m_eoi = 1'b0;

  // Any pull wins; a released line floats high on its pull-up
  assign dio_n_i  = ~((dio_oe ? ~dio_n_o : 8'h00) | m_dio);
  assign dav_n_i  = ~(dav_oe | m_dav);
  assign nrfd_n_i = ~(nrfd_oe | m_nrfd);
  assign ndac_n_i = ~(ndac_oe | m_ndac);
  assign eoi_n_i  = ~(eoi_oe | m_eoi);
  // Lone controller and one instrument: a single talker, far below the device limit
  initial atn_n = 1'b1;

  // Source a byte; bounded waits so a dead acceptor cannot hang us
  task automatic send(input logic atn, input logic [7:0] b, input logic e);
    @(posedge core_clk);
    m_nrfd <= 1'b0;
    m_ndac <= 1'b0;
    atn_n <= ~atn;
    m_dio <= b;
    m_eoi <= e;
    repeat (4) @(posedge core_clk);
    for (int n = 0; n < 200 && !(nrfd_n_i && !ndac_n_i); n++) @(posedge core_clk);
    m_dav <= 1'b1;
    for (int n = 0; n < 200 && !ndac_n_i; n++) @(posedge core_clk);
    m_dav <= 1'b0;
    m_dio <= 8'h00;
    m_eoi <= 1'b0;
    repeat (2) @(posedge core_clk);
    atn_n <= 1'b1;
  endtask

  // Accept one byte from the talker, then hold both lines pulled
  task automatic recv(output logic [7:0] b, output logic e);
    @(posedge core_clk);
    m_ndac <= 1'b1;
    m_nrfd <= 1'b0;
    for (int n = 0; n < 200 && dav_n_i; n++) @(posedge core_clk);
    b = ~dio_n_i;
    e = ~eoi_n_i;
    m_nrfd <= 1'b1;
    m_ndac <= 1'b0;
    for (int n = 0; n < 200 && !dav_n_i; n++) @(posedge core_clk);
    m_ndac <= 1'b1;
  endtask
endmodule // pib_ctrl_model
`default_nettype wire

// ### tb/test_pib_core.sv
// Self-checking bench for the bus interface core
`timescale 1ns/1ps
`default_nettype none
module test_pib_core;
  logic               core_clk = 1'b0, nrst = 1'b0, ifc_n = 1'b1, ren_n = 1'b1;
  logic               svc_req = 1'b0, tx_valid = 1'b0, rx_ready = 1'b1;
  logic [4:0]         prim_addr = 5'h1B;
  pib_pkg::pib_word_s tx_word = '0, rx_word;
  logic [7:0]         dio_n_i, dio_n_o;
  logic               dio_oe, dav_n_i, dav_oe, nrfd_n_i, nrfd_oe, ndac_n_i, ndac_oe;
  logic               eoi_n_i, eoi_oe, atn_n, dav_n_o, nrfd_n_o, ndac_n_o, eoi_n_o;
  logic               srq_n_o, srq_oe, tx_ready, rx_valid, listen_act, talk_act, remote, addr_err;
  int                 err_count = 0, checks = 0, cyc = 0;

  pib_core DUT (.*);
  pib_ctrl_model ctl (.*);

  // Clock and a hang guard well above the few hundred cycles needed
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Let updates land, then look at the falling edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic put_tx(input logic [7:0] b, input logic e);
    @(posedge core_clk);
    tx_word <= '{data: b, last: e};
    tx_valid <= 1'b1;
    for (int n = 0; n < 200; n++) begin
      @(posedge core_clk);
      if (tx_ready === 1'b1) break;
    end
    tx_valid <= 1'b0;
  endtask

  task automatic t_reset;
    chk("listen_act", 0, listen_act);
    chk("bus drive", 0, {dio_oe, dav_oe, eoi_oe});
    chk("acceptor aside", 0, {nrfd_oe, ndac_oe});
    chk("pull levels", 0, {dav_n_o, nrfd_n_o, ndac_n_o, eoi_n_o, srq_n_o});
  endtask

  // Listen, then two data bytes into a stalled receiver
  task automatic t_listen;
    ctl.send(1'b1, 8'h3B, 1'b0);
    tick(6);
    chk("listen_act", 1, listen_act);
    @(posedge core_clk) rx_ready <= 1'b0;
    ctl.send(1'b0, 8'hA5, 1'b0);
    ctl.send(1'b0, 8'h3C, 1'b1);
    tick(8);
    chk("rx_valid", 1, rx_valid);
    chk("rx first", {8'hA5, 1'b0}, rx_word);
    @(posedge core_clk) rx_ready <= 1'b1;
    tick(1);
    chk("rx last", {8'h3C, 1'b1}, rx_word);
    tick(2);
    chk("rx drained", 0, rx_valid);
  endtask

  task automatic t_addr;
    ctl.send(1'b1, 8'h7B, 1'b0);
    tick(6);
    chk("addr_err", 1, addr_err);
    chk("listen kept", 1, listen_act);
    ctl.send(1'b1, 8'h3F, 1'b0);
    tick(6);
    chk("unlisten", 0, listen_act);
  endtask

  task automatic t_talk;
    logic [7:0] b0, b1;
    logic       e0, e1;
    ctl.send(1'b1, 8'h5B, 1'b0);
    tick(6);
    chk("talk_act", 1, talk_act);
    fork
      begin put_tx(8'h5A, 1'b0); put_tx(8'hC3, 1'b1); end
      begin ctl.recv(b0, e0); ctl.recv(b1, e1); end
    join
    chk("tx first", {8'h5A, 1'b0}, {b0, e0});
    chk("tx last", {8'hC3, 1'b1}, {b1, e1});
    // Another talker's address takes the role from us
    ctl.send(1'b1, 8'h45, 1'b0);
    tick(6);
    chk("other talker", 0, talk_act);
    ctl.send(1'b1, 8'h5B, 1'b0);
    tick(6);
    chk("talk again", 1, talk_act);
    ctl.send(1'b1, 8'h5F, 1'b0);
    tick(6);
    chk("untalk", 0, talk_act);
  endtask

  // Highest address, remote, service request, then interface clear
  task automatic t_mgmt;
    @(posedge core_clk);
    prim_addr <= 5'h1E;
    ren_n <= 1'b0;
    svc_req <= 1'b1;
    ctl.send(1'b1, 8'h3E, 1'b0);
    tick(6);
    chk("listen max", 1, listen_act);
    chk("remote", 1, remote);
    chk("srq_oe", 1, srq_oe);
    @(posedge core_clk) ifc_n <= 1'b0;
    tick(8);
    chk("ifc clear", 0, listen_act);
  endtask

  task automatic finish_test;
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    tick(4);
    t_reset();
    t_listen();
    t_addr();
    t_talk();
    t_mgmt();
    finish_test();
  end
endmodule // test_pib_core
`default_nettype wire

bind pib_core pib_core_properties u_props (.*);
